// [inc/mbk_pkg.sv]
// shared constants for the master bus kill and interrupt acknowledge ends
`default_nettype none
package mbk_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int NUM_LOCAL = 4;
    localparam int SRC_W = 3;
    // local source codes, index order is hit priority
    localparam logic [2:0] SRC_SRAM = 3'h0;
    localparam logic [2:0] SRC_ROM = 3'h1;
    localparam logic [2:0] SRC_LFB = 3'h2;
    localparam logic [2:0] SRC_ICACHE = 3'h3;
    localparam logic [2:0] SRC_BUS = 3'h4;
    // transfer encodings
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] TT_NORMAL = 2'h0;
    localparam logic [1:0] TT_IACK_NATIVE = 2'h3;
    localparam logic [1:0] TT_IACK_LEGACY = 2'h0;
    localparam logic [2:0] TM_IACK_LEGACY = 3'h7;
    // interrupt acknowledge address fields
    localparam logic [26:0] IACK_NATIVE_FILL = 27'h7FFFFFF;
    localparam logic [1:0] IACK_NATIVE_LOW = 2'h0;
    localparam logic [27:0] IACK_LEGACY_FILL = 28'hFFFFFFF;
    localparam logic [0:0] IACK_LEGACY_LOW = 1'h1;
    localparam int VEC_MSB = 31;
    localparam int VEC_LSB = 24;
    localparam int WAIT_W = 4;
    typedef enum logic [2:0] {
        MBK_IDLE = 3'h1,
        MBK_START = 3'h2,
        MBK_WAIT = 3'h4
    } mbk_mst_state_t;
    typedef enum logic [2:0] {
        MBK_S_IDLE = 3'h1,
        MBK_S_HOLD = 3'h2,
        MBK_S_DONE = 3'h4
    } mbk_slv_state_t;
endpackage
`default_nettype wire

// [inc/mbk_if.sv]
// master bus and interrupt level wires joining the two ends
`timescale 1ns/10ps
`default_nettype none
interface mbk_if;
    logic xfer_start_n;
    logic cycle_kill_n;
    logic [31:0] bus_addr;
    logic read_not_write;
    logic [1:0] xfer_size;
    logic [1:0] xfer_type;
    logic [2:0] xfer_modifier;
    logic [31:0] bus_read_data;
    logic read_input_enable;
    logic xfer_ack_n;
    logic xfer_err_ack_n;
    logic [2:0] irq_level_n;
    modport master (
        output xfer_start_n, cycle_kill_n, bus_addr, read_not_write,
        output xfer_size, xfer_type, xfer_modifier,
        input bus_read_data, read_input_enable, xfer_ack_n, xfer_err_ack_n,
        input irq_level_n
    );
    modport slave (
        input xfer_start_n, cycle_kill_n, bus_addr, read_not_write,
        input xfer_size, xfer_type, xfer_modifier,
        output bus_read_data, read_input_enable, xfer_ack_n, xfer_err_ack_n,
        output irq_level_n
    );
endinterface
`default_nettype wire

// [hdl/mbk_slave.sv]
// bus slave and interrupting peripheral end of the master bus
`timescale 1ns/10ps
`default_nettype none
module mbk_slave (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    // memory side
    input wire logic [31:0] MEM_DATA,
    input wire logic [3:0] WAIT_CYCLES,
    input wire logic ERR_RESPOND,
    // interrupt source
    input wire logic [2:0] IRQ_REQ_LEVEL,
    input wire logic [7:0] IRQ_VECTOR,
    // observation
    output logic REQ_SEEN,
    output logic [31:0] REQ_ADDR,
    output logic IACK_SEEN,
    // master bus
    mbk_if.slave bus
);
    mbk_pkg::mbk_slv_state_t state;
    logic [mbk_pkg::WAIT_W-1:0] wait_cnt;
    logic is_iack;
    logic [2:0] held_level;
    // acknowledge cycle open from acceptance until its done clock
    logic iack_open;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        is_iack = (bus.xfer_type == mbk_pkg::TT_IACK_NATIVE) ||
            (bus.xfer_type == mbk_pkg::TT_IACK_LEGACY &&
             bus.xfer_modifier == mbk_pkg::TM_IACK_LEGACY &&
             bus.bus_addr[31:4] == mbk_pkg::IACK_LEGACY_FILL);
    end

    // request decode, kill check at the edge opening the second clock
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= mbk_pkg::MBK_S_IDLE;
            wait_cnt <= '0;
            iack_open <= 1'b0;
            REQ_SEEN <= 1'b0;
            REQ_ADDR <= '0;
            IACK_SEEN <= 1'b0;
        end else if (CLK_EN) begin
            REQ_SEEN <= 1'b0;
            IACK_SEEN <= 1'b0;
            case (state)
                mbk_pkg::MBK_S_IDLE: begin
                    if (!bus.xfer_start_n && bus.cycle_kill_n) begin // R5
                        state <= mbk_pkg::MBK_S_HOLD;
                        wait_cnt <= WAIT_CYCLES;
                        REQ_SEEN <= 1'b1;
                        REQ_ADDR <= bus.bus_addr;
                        IACK_SEEN <= is_iack;
                        iack_open <= is_iack;
                    end
                end
                mbk_pkg::MBK_S_HOLD: begin
                    if (wait_cnt == '0) begin
                        state <= mbk_pkg::MBK_S_DONE;
                    end else begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end
                end
                mbk_pkg::MBK_S_DONE: begin
                    state <= mbk_pkg::MBK_S_IDLE; // R7
                    iack_open <= 1'b0;
                end
                default: begin
                    state <= mbk_pkg::MBK_S_IDLE;
                end
            endcase
        end
    end

    // answer drive, one clock wide, nothing while a cycle is killed
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bus.xfer_ack_n <= 1'b1;
            bus.xfer_err_ack_n <= 1'b1;
            bus.read_input_enable <= 1'b0;
            bus.bus_read_data <= '0;
        end else if (CLK_EN) begin
            bus.xfer_ack_n <= 1'b1; // R2 R7
            bus.xfer_err_ack_n <= 1'b1;
            bus.read_input_enable <= 1'b0;
            bus.bus_read_data <= '0;
            if ((state == mbk_pkg::MBK_S_IDLE && !bus.xfer_start_n &&
                 bus.cycle_kill_n && WAIT_CYCLES == '0) ||
                (state == mbk_pkg::MBK_S_HOLD && wait_cnt == 4'h1)) begin
                bus.read_input_enable <= 1'b1;
                bus.xfer_ack_n <= ERR_RESPOND;
                bus.xfer_err_ack_n <= !ERR_RESPOND;
                if (iack_open || (state == mbk_pkg::MBK_S_IDLE && is_iack))
                begin
                    bus.bus_read_data[mbk_pkg::VEC_MSB:mbk_pkg::VEC_LSB]
                        <= IRQ_VECTOR; // R20
                end else begin
                    bus.bus_read_data <= MEM_DATA;
                end
            end
        end
    end

    // request level held until its acknowledge completes
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            held_level <= '0;
        end else if (CLK_EN) begin
            if (held_level == '0) begin
                held_level <= IRQ_REQ_LEVEL; // R12
            end else if (iack_open && state == mbk_pkg::MBK_S_DONE) begin
                held_level <= '0;
            end
        end
    end

    always_comb begin
        bus.irq_level_n = ~held_level; // R10 R13
    end
endmodule
`default_nettype wire

// [hdl/mbk_master.sv]
// processor end of the master bus: kill, single read, interrupt acknowledge
`timescale 1ns/10ps
`default_nettype none
// Function
// R1: start cycle, assert kill on local hit
// R2: killed cycle gets no slave drive
// R3: sram, rom, fill buffer, icache, then bus
// R4: transfer start for exactly first clock
// R5: unkilled cycle: slave drives data, acknowledges
// R6: sample acknowledge each edge, else wait
// R7: slave drops enable, acknowledge next clock
// R8: new start may follow killed cycle
// R9: stall equals bus clocks minus one
// R10: peripheral drives active-low request level
// R11: pending only when level exceeds mask
// R12: peripheral holds level until acknowledged
// R13: level inputs sampled every rising edge
// R14: take at boundary, one handler instruction
// R15: acknowledge mode fixed by static strap
// R16: native mode address and type three
// R17: native modifier is inverted level inputs
// R18: legacy mode address, type zero, modifier seven
// R19: acknowledge is byte read, normal timing
// R20: peripheral returns vector on top byte
// R21: vector latched when acknowledge sampled
// R22: error terminates first, ack normal, else wait
// R23: killed cycle ignores all terminations
module mbk_master (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    // access request
    input wire logic REQ_VALID,
    input wire logic [31:0] REQ_ADDR,
    input wire logic [1:0] REQ_SIZE,
    input wire logic [2:0] REQ_MODIFIER,
    // local lookup, index 0 sram, 1 rom, 2 fill buffer, 3 icache
    input wire logic [3:0] LOCAL_HIT,
    input wire logic [3:0][31:0] LOCAL_DATA,
    // interrupt control
    input wire logic LEGACY_ACK_MODE,
    input wire logic [2:0] IRQ_MASK,
    input wire logic INSN_BOUNDARY,
    input wire logic HIGHER_EXC_PENDING,
    input wire logic HANDLER_INSN_DONE,
    // results
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [31:0] RSP_DATA,
    output logic RSP_ERROR,
    output logic [2:0] RSP_SOURCE,
    output logic PIPE_STALL,
    output logic IRQ_PENDING,
    output logic IRQ_TAKEN,
    output logic IRQ_VECTOR_VALID,
    output logic [7:0] IRQ_VECTOR,
    // master bus
    mbk_if.master bus
);
    mbk_pkg::mbk_mst_state_t state;
    logic [2:0] irq_sampled_n;
    logic [2:0] req_level;
    logic legacy_mode;
    logic strap_done;
    logic handler_gate;
    logic in_iack;
    logic killed;
    logic [31:0] local_q;
    logic [2:0] src_q;
    logic any_hit;
    logic [31:0] hit_data;
    logic [2:0] hit_src;
    logic can_issue;
    logic take_irq;
    logic start_req;
    logic term_ack;
    logic term_err;
    logic terminate;
    logic next_stall;
    logic next_ready;

    ////////////////////////////////////////////////////////////////////////
    // local hit priority
    always_comb begin
        any_hit = |LOCAL_HIT;
        hit_data = '0;
        hit_src = mbk_pkg::SRC_BUS;
        for (int i = mbk_pkg::NUM_LOCAL - 1; i >= 0; i--) begin
            if (LOCAL_HIT[i]) begin // R3
                hit_data = LOCAL_DATA[i];
                hit_src = 3'(i);
            end
        end
    end

    always_comb begin
        req_level = ~irq_sampled_n;
        term_err = !bus.xfer_err_ack_n; // R22
        term_ack = !bus.xfer_ack_n;
        terminate = (state == mbk_pkg::MBK_WAIT) && (term_err || term_ack);
        can_issue = (state == mbk_pkg::MBK_IDLE) ||
            (state == mbk_pkg::MBK_START && killed); // R8
        take_irq = can_issue && strap_done && IRQ_PENDING &&
            INSN_BOUNDARY && !HIGHER_EXC_PENDING && !handler_gate; // R14
        start_req = can_issue && !take_irq && REQ_VALID;
        next_stall = (state == mbk_pkg::MBK_START && !killed) ||
            (state == mbk_pkg::MBK_WAIT && !terminate); // R9
        next_ready = take_irq || start_req ? 1'b0 :
            (state == mbk_pkg::MBK_IDLE) || terminate ||
            (state == mbk_pkg::MBK_START && killed);
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt level sampling and pending test
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_sampled_n <= 3'h7;
            IRQ_PENDING <= 1'b0;
        end else if (CLK_EN) begin
            irq_sampled_n <= bus.irq_level_n; // R13
            IRQ_PENDING <= req_level > IRQ_MASK; // R11
        end
    end

    // acknowledge mode strap caught once after reset release
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            legacy_mode <= 1'b0;
            strap_done <= 1'b0;
        end else if (CLK_EN && !strap_done) begin
            legacy_mode <= LEGACY_ACK_MODE; // R15
            strap_done <= 1'b1;
        end
    end

    // no second interrupt before one handler instruction
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            handler_gate <= 1'b0;
        end else if (CLK_EN) begin
            if (take_irq) begin
                handler_gate <= 1'b1; // R14
            end else if (HANDLER_INSN_DONE && !in_iack) begin
                handler_gate <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle sequencing
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= mbk_pkg::MBK_IDLE;
            in_iack <= 1'b0;
            killed <= 1'b0;
            local_q <= '0;
            src_q <= mbk_pkg::SRC_BUS;
        end else if (CLK_EN) begin
            case (state)
                mbk_pkg::MBK_IDLE, mbk_pkg::MBK_START: begin
                    if (state == mbk_pkg::MBK_START && !killed) begin
                        state <= mbk_pkg::MBK_WAIT;
                    end else if (take_irq || start_req) begin
                        state <= mbk_pkg::MBK_START;
                        in_iack <= take_irq;
                        killed <= start_req && any_hit; // R1
                        local_q <= hit_data;
                        src_q <= hit_src;
                    end else begin
                        state <= mbk_pkg::MBK_IDLE; // R23
                        killed <= 1'b0;
                    end
                end
                mbk_pkg::MBK_WAIT: begin
                    if (terminate) begin // R6
                        state <= mbk_pkg::MBK_IDLE;
                        in_iack <= 1'b0;
                    end
                end
                default: begin
                    state <= mbk_pkg::MBK_IDLE;
                end
            endcase
        end
    end

    // address and control, held from start until termination
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bus.xfer_start_n <= 1'b1;
            bus.cycle_kill_n <= 1'b1;
            bus.bus_addr <= '0;
            bus.read_not_write <= 1'b1;
            bus.xfer_size <= '0;
            bus.xfer_type <= mbk_pkg::TT_NORMAL;
            bus.xfer_modifier <= '0;
        end else if (CLK_EN) begin
            bus.xfer_start_n <= !(take_irq || start_req); // R4
            bus.cycle_kill_n <= !(start_req && any_hit); // R1
            if (take_irq) begin
                bus.read_not_write <= 1'b1; // R19
                bus.xfer_size <= mbk_pkg::SIZE_BYTE;
                if (legacy_mode) begin
                    bus.xfer_type <= mbk_pkg::TT_IACK_LEGACY; // R18
                    bus.xfer_modifier <= mbk_pkg::TM_IACK_LEGACY;
                    bus.bus_addr <= {mbk_pkg::IACK_LEGACY_FILL, req_level,
                        mbk_pkg::IACK_LEGACY_LOW};
                end else begin
                    bus.xfer_type <= mbk_pkg::TT_IACK_NATIVE; // R16
                    bus.xfer_modifier <= ~irq_sampled_n; // R17
                    bus.bus_addr <= {mbk_pkg::IACK_NATIVE_FILL, req_level,
                        mbk_pkg::IACK_NATIVE_LOW};
                end
            end else if (start_req) begin
                bus.read_not_write <= 1'b1;
                bus.xfer_size <= REQ_SIZE;
                bus.xfer_type <= mbk_pkg::TT_NORMAL;
                bus.xfer_modifier <= REQ_MODIFIER;
                bus.bus_addr <= REQ_ADDR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // results toward the pipeline
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RSP_VALID <= 1'b0;
            RSP_DATA <= '0;
            RSP_ERROR <= 1'b0;
            RSP_SOURCE <= mbk_pkg::SRC_BUS;
            IRQ_TAKEN <= 1'b0;
            IRQ_VECTOR_VALID <= 1'b0;
            IRQ_VECTOR <= '0;
            PIPE_STALL <= 1'b0;
            REQ_READY <= 1'b0;
        end else if (CLK_EN) begin
            RSP_VALID <= 1'b0;
            IRQ_VECTOR_VALID <= 1'b0;
            IRQ_TAKEN <= take_irq;
            PIPE_STALL <= next_stall; // R9
            REQ_READY <= next_ready;
            if (state == mbk_pkg::MBK_START && killed) begin
                RSP_VALID <= 1'b1; // R3 R23
                RSP_DATA <= local_q;
                RSP_ERROR <= 1'b0;
                RSP_SOURCE <= src_q;
            end else if (terminate && in_iack) begin
                IRQ_VECTOR_VALID <= 1'b1; // R21
                IRQ_VECTOR <=
                    bus.bus_read_data[mbk_pkg::VEC_MSB:mbk_pkg::VEC_LSB];
                RSP_ERROR <= term_err;
            end else if (terminate) begin
                RSP_VALID <= 1'b1; // R22
                RSP_DATA <= bus.bus_read_data;
                RSP_ERROR <= term_err;
                RSP_SOURCE <= mbk_pkg::SRC_BUS;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/mbk_props.sv]
// concurrent checks on the master bus joining the two ends
`timescale 1ns/10ps
`default_nettype none
module mbk_props (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // master bus
    input wire logic xfer_start_n,
    input wire logic cycle_kill_n,
    input wire logic [31:0] bus_addr,
    input wire logic read_not_write,
    input wire logic [1:0] xfer_size,
    input wire logic [1:0] xfer_type,
    input wire logic [2:0] xfer_modifier,
    input wire logic [31:0] bus_read_data,
    input wire logic read_input_enable,
    input wire logic xfer_ack_n,
    input wire logic xfer_err_ack_n,
    input wire logic [2:0] irq_level_n
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);
    ////////////////////////////////////////////////////////////////////////
    // unkilled cycle open from its start until its termination
    logic in_cycle;
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            in_cycle <= 1'h0;
        end else if (!xfer_start_n && cycle_kill_n) begin
            in_cycle <= 1'h1;
        end else if (!xfer_ack_n || !xfer_err_ack_n) begin
            in_cycle <= 1'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_start;
        !xfer_start_n && cycle_kill_n;
    endsequence
    sequence s_kill;
        !xfer_start_n && !cycle_kill_n;
    endsequence
    sequence s_term;
        !xfer_ack_n || !xfer_err_ack_n;
    endsequence
    sequence s_quiet;
        xfer_ack_n && xfer_err_ack_n && !read_input_enable;
    endsequence
    property p_start_one;
        s_start |=> xfer_start_n;
    endproperty
    property p_kill_with_start;
        !cycle_kill_n |-> !xfer_start_n;
    endproperty
    property p_kill_quiet;
        s_kill |=> s_quiet;
    endproperty
    property p_no_stray;
        s_term |-> in_cycle;
    endproperty
    property p_answer;
        s_start |=> ##[0:16] s_term;
    endproperty
    property p_pulse;
        s_term |=> s_quiet;
    endproperty
    property p_ie;
        read_input_enable |-> s_term;
    endproperty
    property p_hold;
        in_cycle && xfer_start_n |-> $stable(bus_addr)
            && $stable(xfer_type) && $stable(xfer_modifier);
    endproperty
    property p_native;
        !xfer_start_n && xfer_type == 2'h3 |->
            bus_addr == {27'h7FFFFFF, ~irq_level_n, 2'h0}
            && xfer_modifier == ~irq_level_n
            && xfer_size == 2'h1 && read_not_write;
    endproperty
    property p_legacy;
        !xfer_start_n && xfer_type == 2'h0 && xfer_modifier == 3'h7 |->
            bus_addr == {28'hFFFFFFF, ~irq_level_n, 1'h1}
            && xfer_size == 2'h1 && read_not_write;
    endproperty
    property p_rdata_idle;
        !read_input_enable |-> bus_read_data == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data driven outside an answer");
    a_start_one: assert property (p_start_one)
        else $error("unkilled start held longer than one clock");
    a_kill_with_start: assert property (p_kill_with_start)
        else $error("kill seen outside a start clock");
    a_kill_quiet: assert property (p_kill_quiet)
        else $error("slave answered a killed cycle");
    a_no_stray: assert property (p_no_stray)
        else $error("termination outside an open cycle");
    a_answer: assert property (p_answer)
        else $error("unkilled cycle got no termination");
    a_pulse: assert property (p_pulse)
        else $error("acknowledge or enable held past one clock");
    a_ie: assert property (p_ie)
        else $error("input enable without termination");
    a_hold: assert property (p_hold)
        else $error("address or control moved inside a cycle");
    a_native: assert property (p_native)
        else $error("native acknowledge fields wrong");
    a_legacy: assert property (p_legacy)
        else $error("legacy acknowledge fields wrong");
endmodule
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the two master bus ends
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk, rstn, mode, rv, bnd, hexc, hdone, ierr;
    logic [31:0] ra, md, rdat, saddr;
    logic [1:0] rs;
    logic [2:0] rm, mask, lvl, rsrc;
    logic [3:0] hit, ws;
    logic [3:0][31:0] ld;
    logic [7:0] vec, rvec, vlast;
    logic rdy, rsp, rerr, stall, pend, taken, vv, elast;
    int failures = 0, checks = 0, n_take = 0, n_rsp = 0, n_vec = 0, r0 = 0;
    mbk_if mbk_if_i ();
    mbk_master mbk_master_i (
        .CORE_CLK(clk), .RESETN(rstn), .CLK_EN(1'h1), .REQ_VALID(rv),
        .REQ_ADDR(ra), .REQ_SIZE(rs), .REQ_MODIFIER(rm), .LOCAL_HIT(hit),
        .LOCAL_DATA(ld), .LEGACY_ACK_MODE(mode), .IRQ_MASK(mask),
        .INSN_BOUNDARY(bnd), .HIGHER_EXC_PENDING(hexc),
        .HANDLER_INSN_DONE(hdone), .REQ_READY(rdy), .RSP_VALID(rsp),
        .RSP_DATA(rdat), .RSP_ERROR(rerr), .RSP_SOURCE(rsrc),
        .PIPE_STALL(stall), .IRQ_PENDING(pend), .IRQ_TAKEN(taken),
        .IRQ_VECTOR_VALID(vv), .IRQ_VECTOR(rvec), .bus(mbk_if_i)
    );
    mbk_slave mbk_slave_i (
        .CORE_CLK(clk), .RESETN(rstn), .CLK_EN(1'h1), .MEM_DATA(md),
        .WAIT_CYCLES(ws), .ERR_RESPOND(ierr), .IRQ_REQ_LEVEL(lvl),
        .IRQ_VECTOR(vec), .REQ_SEEN(), .REQ_ADDR(saddr), .IACK_SEEN(),
        .bus(mbk_if_i)
    );
    mbk_props mbk_props_i (
        .CORE_CLK(clk), .RESETN(rstn),
        .xfer_start_n(mbk_if_i.xfer_start_n),
        .cycle_kill_n(mbk_if_i.cycle_kill_n),
        .bus_addr(mbk_if_i.bus_addr),
        .read_not_write(mbk_if_i.read_not_write),
        .xfer_size(mbk_if_i.xfer_size), .xfer_type(mbk_if_i.xfer_type),
        .xfer_modifier(mbk_if_i.xfer_modifier),
        .bus_read_data(mbk_if_i.bus_read_data),
        .read_input_enable(mbk_if_i.read_input_enable),
        .xfer_ack_n(mbk_if_i.xfer_ack_n),
        .xfer_err_ack_n(mbk_if_i.xfer_err_ack_n),
        .irq_level_n(mbk_if_i.irq_level_n)
    );
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    initial begin
        #400000;
        failures++;
        finish_test;
    end
    always @(posedge clk) begin
        if (taken === 1'h1) n_take <= n_take + 1;
        if (rsp === 1'h1) n_rsp <= n_rsp + 1;
        if (vv === 1'h1) begin
            n_vec <= n_vec + 1;
            vlast <= rvec;
            elast <= rerr;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic [2:0] src_of(input logic [3:0] h);
        for (int i = 0; i < 4; i++) begin
            if (h[i]) return 3'(i);
        end
        return mbk_pkg::SRC_BUS;
    endfunction
    task automatic rst(input logic m);
        @(posedge clk);
        rstn <= 1'h0;
        mode <= m;
        repeat (10) @(posedge clk);
        rstn <= 1'h1;
        cyc(3);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // one read; local hit or bus cycle with waits and error choice
    task automatic rd(input logic [3:0] h, input logic [3:0] w, input logic e);
        logic [2:0] s;
        logic b;
        int n, st;
        s = src_of(h);
        b = (s == mbk_pkg::SRC_BUS);
        n = 0;
        st = 0;
        while (rdy !== 1'h1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        rv <= 1'h1;
        ra <= {4'h0, 28'($urandom)};
        ld <= {$urandom, $urandom, $urandom, $urandom};
        md <= $urandom;
        rm <= 3'($urandom_range(6));
        rs <= 2'($urandom);
        {hit, ws, ierr} <= {h, w, e};
        @(posedge clk);
        rv <= 1'h0;
        n = 0;
        while (rsp !== 1'h1 && n < 200) begin
            @(negedge clk);
            st += int'(stall === 1'h1);
            n++;
        end
        check(rsp, 1'h1);
        check(rdy, 1'h1);
        check(rsrc, s);
        check(rerr, e && b);
        check(st, b ? 32'(w) + 32'h1 : 32'h0);
        if (!(e && b)) check(rdat, b ? md : ld[s]);
        if (b) check(saddr, ra);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // masked, then pending, blocked, gated, then acknowledged
    task automatic irq(input logic [2:0] l, input logic e, input logic g);
        int t0, v0, n;
        t0 = n_take;
        v0 = n_vec;
        @(posedge clk);
        vec <= 8'($urandom);
        ierr <= e;
        hexc <= 1'h1;
        mask <= 3'($urandom_range(7, l));
        lvl <= l;
        @(posedge clk);
        lvl <= 3'h0;
        cyc(6);
        check(pend, 1'h0);
        @(posedge clk);
        mask <= 3'($urandom_range(l - 1, 0));
        cyc(6);
        check(pend, 1'h1);
        check(n_take, t0);
        @(posedge clk);
        hexc <= 1'h0;
        if (g) begin
            cyc(6);
            check(n_take, t0);
            @(posedge clk);
            hdone <= 1'h1;
            @(posedge clk);
            hdone <= 1'h0;
        end
        n = 0;
        while (n_vec == v0 && n < 60) begin
            @(negedge clk);
            n++;
        end
        check(n_take, t0 + 1);
        check(vlast, vec);
        check(elast, e);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(31));
        {rstn, rv, hexc, hdone, ierr, mode} = '0;
        {ra, md, rs, rm, hit, ws, ld, vec, mask, lvl} = '0;
        bnd = 1'h1;
        rst(1'h0);
        rd(4'hF, 4'h0, 1'h0);
        rd(4'h8, 4'h0, 1'h0);
        rd(4'h0, 4'hF, 1'h0);
        rd(4'h0, 4'h0, 1'h1);
        for (int i = 0; i < 40; i++) begin
            rd($urandom_range(1) ? 4'($urandom) : 4'h0,
                4'($urandom_range(3)), $urandom_range(7) == 0);
        end
        // three killed starts back to back, then a real read
        cyc(4);
        r0 = n_rsp;
        @(posedge clk);
        repeat (3) begin
            {rv, hit, ws, ierr} <= {1'h1, 4'h4, 4'h0, 1'h0};
            @(posedge clk);
        end
        hit <= 4'h0;
        @(posedge clk);
        rv <= 1'h0;
        cyc(20);
        check(n_rsp - r0, 4);
        check(rsrc, mbk_pkg::SRC_BUS);
        check(rdat, md);
        for (int m = 0; m < 2; m++) begin
            rst(m[0]);
            for (int l = 1; l < 8; l++) begin
                irq(3'(l), l == 5, l > 1);
            end
        end
        finish_test;
    end
endmodule
`default_nettype wire
